// >>> srcr_chk.sv
// assertion checker for the switch reset control registers
`timescale 1ns/10ps
`include "srcr_defines.vh"
module srcr_chk (input wire core_clk, input wire rst_n, input wire regWrite, input wire regRead,
    input wire [11:0] regAddr, input wire [31:0] regWdata, input wire [31:0] regRdata,
    input wire fundResetActive, input wire warmResetActive, input wire upstreamLinkDownEvt,
    input wire full_reset_trigger, input wire warm_reset_trigger, input wire lockable_write_enable,
    input wire power_budget_write_enable, input wire no_warm_reset_on_link_down, input wire linkDownWarmReset);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire wCt = regWrite && regAddr == `SRCR_OFF_CONTROL;
    property p_full; wCt && regWdata[`SRCR_CT_FULL] |=> full_reset_trigger; endproperty
    a_full: assert property (p_full) else $error("full trigger pulse missing");
    property p_fullq; !(wCt && regWdata[`SRCR_CT_FULL]) |=> !full_reset_trigger; endproperty
    a_fullq: assert property (p_fullq) else $error("full trigger without write of one");
    property p_warm; wCt && regWdata[`SRCR_CT_WARM] |=> warm_reset_trigger; endproperty
    a_warm: assert property (p_warm) else $error("warm trigger pulse missing");
    property p_warmq; !(wCt && regWdata[`SRCR_CT_WARM]) |=> !warm_reset_trigger; endproperty
    a_warmq: assert property (p_warmq) else $error("warm trigger without write of one");
    property p_rdCt; regRead && regAddr == `SRCR_OFF_CONTROL |=> regRdata[1:0] == 2'h0 && regRdata[31:8] == 24'h0; endproperty
    a_rdCt: assert property (p_rdCt) else $error("control read shows nonzero bits");
    property p_rdSt; regRead && regAddr == `SRCR_OFF_STATUS |=> regRdata[27:23] == 5'h0; endproperty
    a_rdSt: assert property (p_rdSt) else $error("status reserved bits nonzero");
    property p_idle; !regRead |=> regRdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data without read");
    property p_unl; fundResetActive || warmResetActive |=> lockable_write_enable; endproperty
    a_unl: assert property (p_unl) else $error("unlock not set in reset");
    property p_pwr; wCt && !lockable_write_enable && !fundResetActive && !warmResetActive |=> $stable(power_budget_write_enable); endproperty
    a_pwr: assert property (p_pwr) else $error("locked field changed");
    property p_ld; upstreamLinkDownEvt |=> linkDownWarmReset == !$past(no_warm_reset_on_link_down); endproperty
    a_ld: assert property (p_ld) else $error("link down reset gating wrong");
    property p_ldq; !upstreamLinkDownEvt |=> !linkDownWarmReset; endproperty
    a_ldq: assert property (p_ldq) else $error("link down reset without cause");
endmodule // srcr_chk
bind srcr_switch_reset_control_regs srcr_chk chk_i (.*);

// >>> srcr_defines.vh
// constants for the switch reset control register block
`ifndef SRCR_DEFINES_VH
`define SRCR_DEFINES_VH
`define SRCR_ADDR_W 12
`define SRCR_OFF_STATUS 12'h400
`define SRCR_OFF_CONTROL 12'h404
`define SRCR_ST_MERGE 19
`define SRCR_ST_LOCK_LO 20
`define SRCR_ST_LOCK_HI 22
`define SRCR_ST_MARK_LO 28
`define SRCR_ST_MARK_HI 31
`define SRCR_CT_FULL 0
`define SRCR_CT_WARM 1
`define SRCR_CT_HALT 2
`define SRCR_CT_UNLOCK 3
`define SRCR_CT_PWRB 4
`define SRCR_CT_NOLD 5
`define SRCR_CT_SKIPEE 6
`define SRCR_CT_STRICT 7
`define SRCR_LOCK_NONE 3'h0
`define SRCR_MARK_RST 4'h0
`define SRCR_ZERO32 32'h00000000
`define SRCR_BIT_CLR 1'h0
`define SRCR_BIT_SET 1'h1
`endif

// >>> srcr_seq_model.sv
// reset sequencer model driven by the trigger outputs
`timescale 1ns/10ps
module srcr_seq_model (
    input wire core_clk, input wire rst_n, input wire fullReq, input wire warmReq,
    output wire fundAct, output wire warmAct, output wire seqDone);
    reg [2:0] fCnt_reg;
    reg [2:0] wCnt_reg;
    // sequences last a few cycles; real ones are longer but only order matters here
    always @(posedge core_clk) begin
        fCnt_reg <= !rst_n || fullReq ? 3'h6 : fCnt_reg - {2'h0, |fCnt_reg};
        wCnt_reg <= !rst_n ? 3'h0 : warmReq ? 3'h5 : wCnt_reg - {2'h0, |wCnt_reg};
    end
    assign fundAct = |fCnt_reg;
    assign warmAct = |wCnt_reg;
    assign seqDone = !fundAct && !warmAct;
endmodule // srcr_seq_model

// >>> srcr_switch_reset_control_regs.v
// switch status upper fields and switch control register
`timescale 1ns/10ps
`include "srcr_defines.vh"
module srcr_switch_reset_control_regs #(
    parameter LOCK_W = 3
) (
    input wire core_clk,
    input wire rst_n,
    input wire regWrite,
    input wire regRead,
    input wire [`SRCR_ADDR_W-1:0] regAddr,
    input wire [31:0] regWdata,
    output reg [31:0] regRdata,
    input wire pair_fourteen_fifteen_merge_strap,
    input wire [LOCK_W-1:0] upstream_lock_partner,
    input wire fundResetActive,
    input wire warmResetActive,
    input wire resetSeqDone,
    input wire eepromErrorSetHalt,
    input wire upstreamLinkDownEvt,
    output reg full_reset_trigger,
    output reg warm_reset_trigger,
    output reg hold_in_reset,
    output reg lockable_write_enable,
    output reg power_budget_write_enable,
    output reg no_warm_reset_on_link_down,
    output reg skip_eeprom_load_on_warm_reset,
    output reg force_strict_ordering,
    output reg linkDownWarmReset
);
    // captured strap and lock partner
    reg mergeStrap_reg;
    reg mergeStrap_next;
    reg [LOCK_W-1:0] lockPartner_reg;
    reg [LOCK_W-1:0] lockPartner_next;
    // software marker, sticky across hot reset
    reg [3:0] marker_reg;
    reg [3:0] marker_next;
    // next values of the control outputs
    reg fullTrig_next;
    reg warmTrig_next;
    reg hold_next;
    reg unlock_next;
    reg pwrUnlock_next;
    reg noLinkDown_next;
    reg skipLoad_next;
    reg strict_next;
    reg linkDownReset_next;
    reg [31:0] rdata_next;
    // assembled read words
    reg [31:0] statusWord;
    reg [31:0] controlWord;
    // decoded strobes
    wire ctlWr;
    wire stWr;
    wire ctlRd;
    wire stRd;
    wire anyReset;

    ////////////////////////////////////////////////////////////////////
    // true when a strobe hits the given register offset
    function hit;
        input strobe;
        input [`SRCR_ADDR_W-1:0] addr;
        input [`SRCR_ADDR_W-1:0] offset;
        begin
            hit = strobe && (addr == offset);
        end
    endfunction

    // new bit when enabled, otherwise keep the old one
    function take;
        input enable;
        input newBit;
        input oldBit;
        begin
            take = enable ? newBit : oldBit;
        end
    endfunction

    // register decode; unmapped offsets fall through and do nothing
    assign ctlWr = hit(regWrite, regAddr, `SRCR_OFF_CONTROL);
    assign stWr = hit(regWrite, regAddr, `SRCR_OFF_STATUS);
    assign ctlRd = hit(regRead, regAddr, `SRCR_OFF_CONTROL);
    assign stRd = hit(regRead, regAddr, `SRCR_OFF_STATUS);
    // either reset sequence counts as a reset operation in progress
    assign anyReset = fundResetActive || warmResetActive;

    ////////////////////////////////////////////////////////////////////
    // strap follows the pin only while fundamental reset runs, then holds
    always @* begin
        mergeStrap_next = take(fundResetActive, pair_fourteen_fifteen_merge_strap, mergeStrap_reg);
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            mergeStrap_reg <= `SRCR_BIT_CLR;
        end else begin
            mergeStrap_reg <= mergeStrap_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // lock partner is live status; one flop keeps the read path short
    always @* begin
        lockPartner_next = upstream_lock_partner;
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            lockPartner_reg <= `SRCR_LOCK_NONE;
        end else begin
            lockPartner_reg <= lockPartner_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // marker: only rst_n (fundamental) clears it, hot reset never touches it
    always @* begin
        marker_next = stWr ? regWdata[`SRCR_ST_MARK_HI:`SRCR_ST_MARK_LO] : marker_reg;
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            marker_reg <= `SRCR_MARK_RST;
        end else begin
            marker_reg <= marker_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // triggers are one-cycle pulses; writing zero starts nothing
    always @* begin
        fullTrig_next = ctlWr && regWdata[`SRCR_CT_FULL];
        warmTrig_next = ctlWr && regWdata[`SRCR_CT_WARM];
    end

    // back-to-back writes of one keep the pulse high; the sequencer restarts
    always @(posedge core_clk) begin
        if (!rst_n) begin
            full_reset_trigger <= `SRCR_BIT_CLR;
            warm_reset_trigger <= `SRCR_BIT_CLR;
        end else begin
            full_reset_trigger <= fullTrig_next;
            warm_reset_trigger <= warmTrig_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // halt: eeprom error wins; writes count only while a sequence runs
    always @* begin
        if (eepromErrorSetHalt) begin
            hold_next = `SRCR_BIT_SET;
        end else begin
            hold_next = take(ctlWr && !resetSeqDone, regWdata[`SRCR_CT_HALT], hold_in_reset);
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            hold_in_reset <= `SRCR_BIT_CLR;
        end else begin
            hold_in_reset <= hold_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // unlock forced on while either reset sequence runs so the eeprom load can write; rst_n clears it
    always @* begin
        if (anyReset) begin
            unlock_next = `SRCR_BIT_SET;
        end else begin
            unlock_next = take(ctlWr, regWdata[`SRCR_CT_UNLOCK], lockable_write_enable);
        end
    end

    // a write that lands during a reset is lost; software must rewrite
    always @(posedge core_clk) begin
        if (!rst_n) begin
            lockable_write_enable <= `SRCR_BIT_CLR;
        end else begin
            lockable_write_enable <= unlock_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // power budget unlock is lockable: gated by the current unlock bit
    always @* begin
        pwrUnlock_next = take(ctlWr && lockable_write_enable, regWdata[`SRCR_CT_PWRB],
            power_budget_write_enable);
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            power_budget_write_enable <= `SRCR_BIT_CLR;
        end else begin
            power_budget_write_enable <= pwrUnlock_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // link-down hot reset disable; sticky, ignores warmResetActive
    always @* begin
        noLinkDown_next = take(ctlWr, regWdata[`SRCR_CT_NOLD], no_warm_reset_on_link_down);
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            no_warm_reset_on_link_down <= `SRCR_BIT_CLR;
        end else begin
            no_warm_reset_on_link_down <= noLinkDown_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // skip of the eeprom step in hot reset; sticky
    always @* begin
        skipLoad_next = take(ctlWr, regWdata[`SRCR_CT_SKIPEE], skip_eeprom_load_on_warm_reset);
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            skip_eeprom_load_on_warm_reset <= `SRCR_BIT_CLR;
        end else begin
            skip_eeprom_load_on_warm_reset <= skipLoad_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // strict ordering of all transactions; sticky
    always @* begin
        strict_next = take(ctlWr, regWdata[`SRCR_CT_STRICT], force_strict_ordering);
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            force_strict_ordering <= `SRCR_BIT_CLR;
        end else begin
            force_strict_ordering <= strict_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // link-down hot reset request, qualified by the disable bit
    always @* begin
        linkDownReset_next = upstreamLinkDownEvt && !no_warm_reset_on_link_down;
    end

    // a write of the disable bit takes effect from the next event on
    always @(posedge core_clk) begin
        if (!rst_n) begin
            linkDownWarmReset <= `SRCR_BIT_CLR;
        end else begin
            linkDownWarmReset <= linkDownReset_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // status word; reserved bits stay zero
    always @* begin
        statusWord = `SRCR_ZERO32;
        statusWord[`SRCR_ST_MERGE] = mergeStrap_reg;
        statusWord[`SRCR_ST_LOCK_HI:`SRCR_ST_LOCK_LO] = lockPartner_reg;
        statusWord[`SRCR_ST_MARK_HI:`SRCR_ST_MARK_LO] = marker_reg;
    end

    // control word; trigger and reserved bits come back zero
    always @* begin
        controlWord = `SRCR_ZERO32;
        controlWord[`SRCR_CT_HALT] = hold_in_reset;
        controlWord[`SRCR_CT_UNLOCK] = lockable_write_enable;
        controlWord[`SRCR_CT_PWRB] = power_budget_write_enable;
        controlWord[`SRCR_CT_NOLD] = no_warm_reset_on_link_down;
        controlWord[`SRCR_CT_SKIPEE] = skip_eeprom_load_on_warm_reset;
        controlWord[`SRCR_CT_STRICT] = force_strict_ordering;
    end

    ////////////////////////////////////////////////////////////////////
    // read mux; a read in the same cycle as a write shows the old value
    always @* begin
        if (stRd) begin
            rdata_next = statusWord;
        end else if (ctlRd) begin
            rdata_next = controlWord;
        end else begin
            rdata_next = `SRCR_ZERO32;
        end
    end

    // registered read data, one cycle after the read strobe, then zero
    always @(posedge core_clk) begin
        if (!rst_n) begin
            regRdata <= `SRCR_ZERO32;
        end else begin
            regRdata <= rdata_next;
        end
    end
endmodule // srcr_switch_reset_control_regs

// >>> test_switch_reset_control_regs.sv
// self-checking bench for the switch reset control registers
`timescale 1ns/10ps
module test_switch_reset_control_regs;
    reg core_clk = 0, rst_n = 0, regWrite = 0, regRead = 0, strap = 1, halt = 0, lde = 0;
    reg [11:0] regAddr = 12'h000;
    reg [31:0] regWdata = 32'h00000000;
    reg [2:0] lockP = 3'h5;
    wire [31:0] regRdata;
    wire fAct, wAct, sDone, fTrig, wTrig, hold;
    wire unl, pwr, noLd, skip, strict, ldwr;
    integer errors = 0, num_checks = 0, cyc = 0;
    srcr_switch_reset_control_regs dut (.core_clk(core_clk), .rst_n(rst_n), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .pair_fourteen_fifteen_merge_strap(strap), .upstream_lock_partner(lockP), .fundResetActive(fAct),
        .warmResetActive(wAct), .resetSeqDone(sDone), .eepromErrorSetHalt(halt), .upstreamLinkDownEvt(lde),
        .full_reset_trigger(fTrig), .warm_reset_trigger(wTrig), .hold_in_reset(hold), .lockable_write_enable(unl),
        .power_budget_write_enable(pwr), .no_warm_reset_on_link_down(noLd), .skip_eeprom_load_on_warm_reset(skip),
        .force_strict_ordering(strict), .linkDownWarmReset(ldwr));
    srcr_seq_model seq (.core_clk(core_clk), .rst_n(rst_n), .fullReq(fTrig), .warmReq(wTrig),
        .fundAct(fAct), .warmAct(wAct), .seqDone(sDone));
    initial forever #5 core_clk = !core_clk;
    // hang guard well above the roughly 55 cycles the run needs
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin errors = errors + 1; final_report; end
    end
    task final_report; begin
        if (errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    end endtask
    task chk(input [31:0] got, input [31:0] exp); begin
        num_checks = num_checks + 1;
        if (got !== exp) begin errors = errors + 1; $display("BAD %0t got %h exp %h", $time, got, exp); end
    end endtask
    // all driving happens at the falling edge, so the design samples settled inputs
    task wr(input [11:0] a, input [31:0] d); begin
        regAddr = a; regWdata = d; regWrite = 1; @(negedge core_clk); regWrite = 0;
    end endtask
    task rd(input [11:0] a, input [31:0] e); begin
        regAddr = a; regRead = 1; @(negedge core_clk); regRead = 0; chk(regRdata, e);
        @(negedge core_clk); // gap so the next strobe is not re-driven in the same step
    end endtask
    task settle; begin
        repeat (2) @(negedge core_clk);
        while (!sDone) @(negedge core_clk);
    end endtask
    task t_boot; begin
        lockP = 3'h2; settle; strap = 0;
        rd(12'h400, 32'h00280000);
        rd(12'h404, 32'h00000008);
        rd(12'h408, 32'h00000000);
    end endtask
    task t_ctl; begin
        wr(12'h404, 32'hFFFFFFFC); rd(12'h404, 32'h000000F8);
        chk({27'h0, strict, skip, noLd, pwr, unl}, 32'h0000001F);
        wr(12'h404, 32'h000000F0); @(negedge core_clk);
        wr(12'h404, 32'h00000000); rd(12'h404, 32'h00000010);
        lde = 1; @(negedge core_clk); lde = 0; chk({31'h0, ldwr}, 32'h1);
        wr(12'h404, 32'h00000020); lde = 1; @(negedge core_clk); lde = 0; chk({31'h0, ldwr}, 32'h0);
    end endtask
    task t_warm; begin
        wr(12'h400, 32'hFFFFFFFF); @(negedge core_clk);
        wr(12'h404, 32'h00000022); chk({31'h0, wTrig}, 32'h1);
        settle; rd(12'h400, 32'hF0280000);
        rd(12'h404, 32'h00000038);
    end endtask
    task t_halt; begin
        halt = 1; @(negedge core_clk); halt = 0; chk({31'h0, hold}, 32'h1);
        wr(12'h404, 32'h00000018); rd(12'h404, 32'h0000001C);
        wr(12'h404, 32'h00000019); chk({31'h0, fTrig}, 32'h1);
    end endtask
    initial begin
        repeat (12) @(negedge core_clk);
        rst_n = 1;
        t_boot; t_ctl; t_warm; t_halt;
        final_report;
    end
endmodule // test_switch_reset_control_regs
